// *** core/bank1_params_map.svh ***
// offsets, field positions, write masks and reset value of the bank 1 parameter registers
`ifndef BANK1_PARAMS_MAP_SVH
`define BANK1_PARAMS_MAP_SVH

// register byte offsets on the configuration port
`define OFS_BANK1_CYCLE_TIME_REG        8'hb8
`define OFS_BANK1_MODULE_PARAMS         8'hc0
`define OFS_BANK1_TIMING_LAT_MINUS_ONE  8'hc4
`define OFS_BANK1_TIMING_LAT_MINUS_TWO  8'hc8

// reset value shared by every register
`define BANK1_REG_RESET                 32'h0000_0000

// writable (implemented) bits of each register, the rest are reserved
`define MASK_BANK1_CYCLE_TIME_REG       32'h0000_ff00
`define MASK_BANK1_MODULE_PARAMS        32'h00ff_ffff
`define MASK_BANK1_TIMING_LAT_MINUS_ONE 32'hff00_0000
`define MASK_BANK1_TIMING_LAT_MINUS_TWO 32'hff00_ff00

// field positions (low bit of each 8-bit field)
`define POS_CYCLE_TIME_AT_MAX_LATENCY   8
`define POS_CAS_LATENCY_SUPPORT_MASK    16
`define POS_INTERNAL_BANK_COUNT         8
`define POS_BURST_LENGTH_SUPPORT_MASK   0
`define POS_CYCLE_TIME_LAT_MINUS_ONE    24
`define POS_ROW_PRECHARGE_MIN           24
`define POS_CYCLE_TIME_LAT_MINUS_TWO    8

// weight of the upper nibble in tenths of a nanosecond
`define NIBBLE_TENTHS_WEIGHT            8'h0a

`endif

// *** core/bank1_params_pkg.sv ***
// types shared by the bank 1 parameter register block
`default_nettype none

package bank1_params_pkg;

	// register slot index inside the storage array
	typedef enum logic [1:0] {
		SLOT_CYCLE     = 2'h0,
		SLOT_PARAMS    = 2'h1,
		SLOT_MINUS_ONE = 2'h2,
		SLOT_MINUS_TWO = 2'h3
	} reg_slot_t;

	// configuration port request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	// decoded module parameters handed to the memory controller
	typedef struct packed {
		logic [7:0] cas_latency_support_mask;
		logic [7:0] internal_bank_count;
		logic [7:0] burst_length_support_mask;
		logic [7:0] cycle_time_at_max_latency_tenths;
		logic [7:0] cycle_time_latency_minus_one_tenths;
		logic [7:0] cycle_time_latency_minus_two_quarters;
		logic [7:0] row_precharge_min_ns;
	} bank_params_t;

endpackage

`default_nettype wire

// *** core/memory_bank_param_regs.sv ***
// bank 1 module parameter registers with decoded outputs for the memory controller
`timescale 1ns/1ps
`default_nettype none
`include "bank1_params_map.svh"

module memory_bank_param_regs (
	input  wire logic                            SYS_CLK_IN,
	input  wire logic                            RST_N_IN,
	input  wire bank1_params_pkg::cfg_req_t      CFG_REQ_IN,
	output logic [31:0]                          CFG_RDATA_OUT,
	output logic                                 CFG_RVALID_OUT,
	input  wire logic [7:0]                      BURST_LEN_REQ_IN,
	output bank1_params_pkg::bank_params_t       PARAMS_OUT,
	output logic                                 MODULE_COMPAT_OUT
);
	import bank1_params_pkg::*;

	// address decode, used by both the write and the read path
	function automatic logic [2:0] slot_decode(input logic [7:0] addr);
		unique case (addr)
			`OFS_BANK1_CYCLE_TIME_REG:       slot_decode = {1'b1, SLOT_CYCLE};
			`OFS_BANK1_MODULE_PARAMS:        slot_decode = {1'b1, SLOT_PARAMS};
			`OFS_BANK1_TIMING_LAT_MINUS_ONE: slot_decode = {1'b1, SLOT_MINUS_ONE};
			`OFS_BANK1_TIMING_LAT_MINUS_TWO: slot_decode = {1'b1, SLOT_MINUS_TWO};
			default:                         slot_decode = 3'h0;
		endcase
	endfunction

	// implemented bits of a slot
	function automatic logic [31:0] slot_mask(input logic [1:0] slot);
		unique case (slot)
			SLOT_CYCLE:     slot_mask = `MASK_BANK1_CYCLE_TIME_REG;
			SLOT_PARAMS:    slot_mask = `MASK_BANK1_MODULE_PARAMS;
			SLOT_MINUS_ONE: slot_mask = `MASK_BANK1_TIMING_LAT_MINUS_ONE;
			default:        slot_mask = `MASK_BANK1_TIMING_LAT_MINUS_TWO;
		endcase
	endfunction

	// nibble-split time to tenths of a nanosecond
	function automatic logic [7:0] nibble_to_tenths(input logic [7:0] v);
		nibble_to_tenths = 8'(8'(v[7:4]) * `NIBBLE_TENTHS_WEIGHT + 8'(v[3:0]));
	endfunction

	logic [31:0]  regs_ff [4];
	logic [2:0]   wr_dec;
	logic [2:0]   rd_dec;
	logic [31:0]  be_bits;
	logic [31:0]  nxt_rdata;
	bank_params_t nxt_params;
	bank_params_t params_ff;
	logic [31:0]  rdata_ff;
	logic         rvalid_ff;
	logic         compat_ff;

	assign wr_dec = slot_decode(CFG_REQ_IN.addr);
	assign rd_dec = wr_dec;
	assign be_bits = {{8{CFG_REQ_IN.be[3]}}, {8{CFG_REQ_IN.be[2]}}, {8{CFG_REQ_IN.be[1]}}, {8{CFG_REQ_IN.be[0]}}};

	// register storage, one slot per register; reserved bits never load
	generate
		for (genvar i = 0; i < 4; i++) begin : g_slot
			logic [31:0] wmask;
			assign wmask = be_bits & slot_mask(2'(i));
			always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					regs_ff[i] <= `BANK1_REG_RESET;
				end else if (CFG_REQ_IN.wr && wr_dec[2] && wr_dec[1:0] == 2'(i)) begin
					regs_ff[i] <= (regs_ff[i] & ~wmask) | (CFG_REQ_IN.wdata & wmask);
				end
			end
		end
	endgenerate

	// read mux, unmapped offsets read as zero
	always_comb begin
		nxt_rdata = rd_dec[2] ? regs_ff[rd_dec[1:0]] : 32'h0000_0000;
	end

	// read answer, one cycle after the strobe
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata_ff  <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= CFG_REQ_IN.rd ? nxt_rdata : 32'h0000_0000;
			rvalid_ff <= CFG_REQ_IN.rd;
		end
	end

	// field decode toward the controller
	always_comb begin
		nxt_params.cas_latency_support_mask  = regs_ff[SLOT_PARAMS][`POS_CAS_LATENCY_SUPPORT_MASK +: 8];
		nxt_params.internal_bank_count       = regs_ff[SLOT_PARAMS][`POS_INTERNAL_BANK_COUNT +: 8];
		nxt_params.burst_length_support_mask = regs_ff[SLOT_PARAMS][`POS_BURST_LENGTH_SUPPORT_MASK +: 8];
		nxt_params.cycle_time_at_max_latency_tenths =
			nibble_to_tenths(regs_ff[SLOT_CYCLE][`POS_CYCLE_TIME_AT_MAX_LATENCY +: 8]);
		nxt_params.cycle_time_latency_minus_one_tenths =
			nibble_to_tenths(regs_ff[SLOT_MINUS_ONE][`POS_CYCLE_TIME_LAT_MINUS_ONE +: 8]);
		nxt_params.cycle_time_latency_minus_two_quarters =
			regs_ff[SLOT_MINUS_TWO][`POS_CYCLE_TIME_LAT_MINUS_TWO +: 8];
		nxt_params.row_precharge_min_ns = regs_ff[SLOT_MINUS_TWO][`POS_ROW_PRECHARGE_MIN +: 8];
	end

	// decoded parameters and compatibility flag, registered
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			params_ff <= '0;
			compat_ff <= 1'b0;
		end else begin
			params_ff <= nxt_params;
			compat_ff <= |(nxt_params.burst_length_support_mask & BURST_LEN_REQ_IN);
		end
	end

	assign CFG_RDATA_OUT     = rdata_ff;
	assign CFG_RVALID_OUT    = rvalid_ff;
	assign PARAMS_OUT        = params_ff;
	assign MODULE_COMPAT_OUT = compat_ff;

	// checks
	property p_reset_zero;
		@(posedge SYS_CLK_IN) $rose(RST_N_IN) |-> (regs_ff[1] == 32'h0000_0000 && regs_ff[2] == 32'h0000_0000
			&& regs_ff[3] == 32'h0000_0000 && regs_ff[0] == 32'h0000_0000);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

	property p_params_write;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(CFG_REQ_IN.wr && CFG_REQ_IN.addr == 8'hc0 && CFG_REQ_IN.be == 4'hf)
		|=> regs_ff[1] == ($past(CFG_REQ_IN.wdata) & 32'h00ff_ffff);
	endproperty
	a_params_write: assert property (p_params_write) else $error("C0h write not stored");

	property p_reserved_zero;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(regs_ff[1][31:24] == 8'h00) && (regs_ff[2][23:0] == 24'h00_0000)
		&& (regs_ff[3] & 32'h00ff_00ff) == 32'h0000_0000 && (regs_ff[0] & 32'hffff_00ff) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_read_back;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(CFG_REQ_IN.rd && CFG_REQ_IN.addr == 8'hc8) |=> CFG_RVALID_OUT && CFG_RDATA_OUT == $past(regs_ff[3]);
	endproperty
	a_read_back: assert property (p_read_back) else $error("C8h read wrong");

	property p_unmapped_zero;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(CFG_REQ_IN.rd && slot_decode(CFG_REQ_IN.addr) == 3'h0) |=> CFG_RDATA_OUT == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_compat;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		##1 MODULE_COMPAT_OUT == |($past(regs_ff[1][7:0]) & $past(BURST_LEN_REQ_IN));
	endproperty
	a_compat: assert property (p_compat) else $error("compatibility flag wrong");

	property p_minus_one_tenths;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		##1 PARAMS_OUT.cycle_time_latency_minus_one_tenths ==
			8'($past(regs_ff[2][31:28]) * 10 + $past(regs_ff[2][27:24]));
	endproperty
	a_minus_one_tenths: assert property (p_minus_one_tenths) else $error("minus one decode wrong");

	property p_fields_follow;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(CFG_REQ_IN.wr && CFG_REQ_IN.addr == 8'hc0 && CFG_REQ_IN.be == 4'hf && !$past(CFG_REQ_IN.wr))
		|-> ##2 PARAMS_OUT.internal_bank_count == $past(CFG_REQ_IN.wdata[15:8], 2)
		&& PARAMS_OUT.cas_latency_support_mask == $past(CFG_REQ_IN.wdata[23:16], 2);
	endproperty
	a_fields_follow: assert property (p_fields_follow) else $error("decoded fields lag wrong");

	property p_minus_two;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		##1 PARAMS_OUT.cycle_time_latency_minus_two_quarters == $past(regs_ff[3][15:8])
		&& PARAMS_OUT.row_precharge_min_ns == $past(regs_ff[3][31:24]);
	endproperty
	a_minus_two: assert property (p_minus_two) else $error("C8h decode wrong");

	property p_hold;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!CFG_REQ_IN.wr |=> $stable(regs_ff[0]) && $stable(regs_ff[2]);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write");

	property p_rdata_idle;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!CFG_REQ_IN.rd |=> !CFG_RVALID_OUT && CFG_RDATA_OUT == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read answer stands too long");

	property p_burst_field;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		##1 PARAMS_OUT.burst_length_support_mask == $past(regs_ff[1][7:0]);
	endproperty
	a_burst_field: assert property (p_burst_field) else $error("burst mask decode wrong");

	property p_max_latency;
		@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		##1 PARAMS_OUT.cycle_time_at_max_latency_tenths ==
			8'($past(regs_ff[0][15:12]) * 10 + $past(regs_ff[0][11:8]));
	endproperty
	a_max_latency: assert property (p_max_latency) else $error("max latency decode wrong");

	c_compat: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) $rose(MODULE_COMPAT_OUT));
	c_read_c4: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		CFG_REQ_IN.rd && CFG_REQ_IN.addr == 8'hc4 ##1 CFG_RDATA_OUT != 32'h0000_0000);
	c_partial_be: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		CFG_REQ_IN.wr && CFG_REQ_IN.be == 4'h2 && CFG_REQ_IN.addr == 8'hc0);

endmodule

`default_nettype wire

// *** tb/memory_bank_param_regs_tb_top.sv ***
// self-checking testbench for the bank 1 parameter registers
`timescale 1ns/1ps
`default_nettype none

module memory_bank_param_regs_tb_top;
	import bank1_params_pkg::*;

	logic         sys_clk;
	logic         rst_n;
	cfg_req_t     req;
	logic [31:0]  rdata;
	logic         rvalid;
	logic [7:0]   burst_req;
	bank_params_t params;
	logic         compat;
	int           err_total;
	int           checks_done;
	logic [7:0]   offs [4]  = '{8'hb8, 8'hc0, 8'hc4, 8'hc8};
	logic [31:0]  masks [4] = '{32'h0000_ff00, 32'h00ff_ffff, 32'hff00_0000, 32'hff00_ff00};

	memory_bank_param_regs dut (
		.SYS_CLK_IN        (sys_clk),
		.RST_N_IN          (rst_n),
		.CFG_REQ_IN        (req),
		.CFG_RDATA_OUT     (rdata),
		.CFG_RVALID_OUT    (rvalid),
		.BURST_LEN_REQ_IN  (burst_req),
		.PARAMS_OUT        (params),
		.MODULE_COMPAT_OUT (compat)
	);

	// free-running 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	// compare one value, count it and report a mismatch
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// compare the decoded parameter word
	task automatic chk_params(input logic [55:0] exp);
		chk({8'h00, params}, {8'h00, exp});
	endtask

	// compare the compatibility flag
	task automatic chk_compat(input logic exp);
		chk({63'h0, compat}, {63'h0, exp});
	endtask

	// one-cycle write pulse on the configuration port
	task automatic reg_wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
		@(posedge sys_clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: addr, be: be, wdata: data};
		@(posedge sys_clk);
		req <= '0;
	endtask

	// one-cycle read pulse, answer sampled after the following edge
	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
		@(posedge sys_clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: addr, be: 4'h0, wdata: 32'h0};
		@(posedge sys_clk);
		req <= '0;
		#1;
		chk({63'h0, rvalid}, 64'h1);
		chk({32'h0, rdata}, {32'h0, exp});
	endtask

	// settle decoded outputs two edges after a change
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// print counts and the verdict, then end the run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// watchdog against a hung run
	initial begin
		repeat (3000) @(posedge sys_clk);
		err_total++;
		stop_test();
	end

	// main sequence
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		burst_req = 8'h00;
		err_total = 0;
		checks_done = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rd_chk(offs[i], 32'h0000_0000);
		chk_params(56'h0);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			reg_wr(offs[i], 4'hf, 32'hffff_ffff);
			rd_chk(offs[i], masks[i]);
		end
		reg_wr(8'hc0, 4'h2, 32'h1234_5678);
		rd_chk(8'hc0, 32'h00ff_56ff);
		$display("test masks and byte enables done");
		reg_wr(8'hc0, 4'hf, 32'h0042_0804);
		reg_wr(8'hc4, 4'hf, 32'h7500_0000);
		reg_wr(8'hc8, 4'hf, 32'h3300_2700);
		reg_wr(8'hb8, 4'hf, 32'h0000_3a00);
		settle();
		chk_params({8'h42, 8'h08, 8'h04, 8'd40, 8'd75, 8'h27, 8'h33});
		rd_chk(8'hc0, 32'h0042_0804);
		$display("test field decode done");
		@(posedge sys_clk);
		burst_req <= 8'h04;
		settle();
		chk_compat(1'b1);
		@(posedge sys_clk);
		burst_req <= 8'hfb;
		settle();
		chk_compat(1'b0);
		@(posedge sys_clk);
		burst_req <= 8'hff;
		reg_wr(8'hc0, 4'h1, 32'h0000_0000);
		settle();
		chk_compat(1'b0);
		$display("test compatibility done");
		reg_wr(8'hcc, 4'hf, 32'hffff_ffff);
		rd_chk(8'hcc, 32'h0000_0000);
		rd_chk(8'hc4, 32'h7500_0000);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		rd_chk(8'hc8, 32'h0000_0000);
		chk_params(56'h0);
		$display("test unmapped and mid-run reset done");
		stop_test();
	end
endmodule

`default_nettype wire
